/* File: common/asr_pkg.sv */
// constants, field layout and carrier types of the alert summary register block
// assumes a 32-bit apb slave port with byte addressing, one register per aligned word
package asr_pkg;

	localparam int NUM_CELLS = 14;
	localparam int NUM_AUX   = 6;
	localparam int NUM_CAL   = 5;
	localparam int REG_W     = 16;
	localparam int DATA_W    = 32;
	localparam int ADDR_W    = 8;

	// summary register index as printed; byte address is four times the index
	localparam logic [ADDR_W-1:0] IDX_ALERT_SUMMARY  = 8'h07;
	localparam logic [ADDR_W-1:0] ADDR_ALERT_SUMMARY = {IDX_ALERT_SUMMARY[5:0], 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_CELL_OV_EN    = 8'h40;
	localparam logic [ADDR_W-1:0] ADDR_CELL_UV_EN    = 8'h44;
	localparam logic [ADDR_W-1:0] ADDR_AUX_EN        = 8'h48;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS    = 8'h4C;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK      = 8'h50;

	// summary bit positions
	localparam int BIT_ADC_CELL_OV  = 15;
	localparam int BIT_COMP_CELL_OV = 14;
	localparam int BIT_ADC_CELL_UV  = 13;
	localparam int BIT_COMP_CELL_UV = 12;
	localparam int BIT_ADC_AUX_COLD = 11;
	localparam int BIT_COMP_AUX_COLD = 10;
	localparam int BIT_ADC_AUX_HOT  = 9;
	localparam int BIT_COMP_AUX_HOT = 8;
	localparam int BIT_CAL_LSB      = 0;
	// calibration fault order inside the cal field, lsb first
	localparam int CAL_RAMP_GAIN    = 0;
	localparam int CAL_PYRAMID_GAIN = 1;
	localparam int CAL_RATIO_OFFSET = 2;
	localparam int CAL_RAMP_OFFSET  = 3;
	localparam int CAL_ADC_OFFSET   = 4;
	// aux enable register: cold enables at the bottom, hot enables from this bit
	localparam int AUX_HOT_LSB      = 8;

	localparam logic [REG_W-1:0]     SUMMARY_RST = 16'h0000;
	localparam logic [NUM_CELLS-1:0] CELL_EN_RST = 14'h0000;
	localparam logic [NUM_AUX-1:0]   AUX_EN_RST  = 6'h00;

	// per-channel alert conditions or latched alert vectors, same layout
	typedef struct packed {
		logic [NUM_CELLS-1:0] cell_ov_vector;
		logic [NUM_CELLS-1:0] comp_cell_ov_vector;
		logic [NUM_CELLS-1:0] cell_uv_vector;
		logic [NUM_CELLS-1:0] comp_cell_uv_vector;
		logic [NUM_AUX-1:0]   aux_cold_vector;
		logic [NUM_AUX-1:0]   comp_aux_cold_vector;
		logic [NUM_AUX-1:0]   aux_hot_vector;
		logic [NUM_AUX-1:0]   comp_aux_hot_vector;
	} asr_alert_vec_t;

	// calibration results: eval pulses with the bounds check of that result
	typedef struct packed {
		logic [NUM_CAL-1:0] eval;
		logic [NUM_CAL-1:0] in_bounds;
	} asr_cal_evt_t;

	typedef struct packed {
		logic              err;
		logic [DATA_W-1:0] data;
	} asr_rsp_t;

	typedef struct packed {
		asr_alert_vec_t       vec;
		logic [NUM_CAL-1:0]   cal_fault;
		logic [NUM_CELLS-1:0] cell_ov_alert_enable;
		logic [NUM_CELLS-1:0] cell_uv_alert_enable;
		logic [NUM_AUX-1:0]   aux_cold_alert_enable;
		logic [NUM_AUX-1:0]   aux_hot_alert_enable;
		logic [REG_W-1:0]     summary;
		logic [REG_W-1:0]     irq_status;
		logic [REG_W-1:0]     irq_mask;
		logic                 irq;
		logic [DATA_W-1:0]    prdata;
		logic                 pslverr;
	} asr_state_t;

endpackage

/* File: rtl/asr_alert_summary.sv */
// alert summary register: latches enabled per-channel alerts at each acquisition,
// folds them into summary bits, tracks calibration faults, apb slave and interrupt
// assumes acquisition and calibration strobes are one-cycle pulses on core_clk_i
//
// Function
// - bit 15 is OR of the fourteen adc cell overvoltage alerts
// - bit 14 is OR of the fourteen comparator cell overvoltage alerts
// - bit 13 is OR of the fourteen adc cell undervoltage alerts
// - bit 12 is OR of the fourteen comparator cell undervoltage alerts
// - bit 11 is OR of the six adc aux cold alerts
// - bit 10 is OR of the six comparator aux cold alerts
// - bit 9 is OR of the six adc aux hot alerts
// - bit 8 is OR of the six comparator aux hot alerts
// - overvoltage summaries clear at next acquisition only if all enabled causes resolved
// - undervoltage summaries clear at next acquisition only if all enabled causes resolved
// - bit 4 is set on an out-of-bounds adc offset calibration, else zero
// - bit 4 clears only on a later in-bounds adc offset calibration; writes cannot clear it
// - summary at index 0x07, read only, resets to zero, bits 7 to 5 unused
// - bits 3 to 0 flag the other calibration faults, clearing the same way
// - a cell overvoltage alert is taken only while its enable bit is one
`timescale 1ns/1ps

module asr_alert_summary
	import asr_pkg::*;
(
	input  wire logic                 core_clk_i,      // core clock, 200 MHz
	input  wire logic                 rst_n_i,         // async reset, active low
	input  wire logic                 psel_i,          // apb select
	input  wire logic                 penable_i,       // apb access phase
	input  wire logic                 pwrite_i,        // apb direction, 1 = write
	input  wire logic [ADDR_W-1:0]    paddr_i,         // apb byte address
	input  wire logic [DATA_W-1:0]    pwdata_i,        // apb write data
	output logic      [DATA_W-1:0]    prdata_o,        // apb read data
	output logic                      pready_o,        // apb ready
	output logic                      pslverr_o,       // apb error
	input  wire asr_alert_vec_t       alert_cond_i,    // live threshold conditions
	input  wire logic                 acq_done_i,      // acquisition complete pulse
	input  wire asr_cal_evt_t         cal_evt_i,       // calibration result pulses
	output logic      [REG_W-1:0]     alert_summary_o, // summary register value
	output logic                      irq_o            // level interrupt
);

	asr_state_t s;
	asr_state_t next_s;

	// fold latched vectors and calibration faults into the summary word
	function automatic logic [REG_W-1:0] asr_summary(input asr_state_t st);
		logic [REG_W-1:0] r;
		r = SUMMARY_RST;
		r[BIT_ADC_CELL_OV]   = |st.vec.cell_ov_vector;
		r[BIT_COMP_CELL_OV]  = |st.vec.comp_cell_ov_vector;
		r[BIT_ADC_CELL_UV]   = |st.vec.cell_uv_vector;
		r[BIT_COMP_CELL_UV]  = |st.vec.comp_cell_uv_vector;
		r[BIT_ADC_AUX_COLD]  = |st.vec.aux_cold_vector;
		r[BIT_COMP_AUX_COLD] = |st.vec.comp_aux_cold_vector;
		r[BIT_ADC_AUX_HOT]   = |st.vec.aux_hot_vector;
		r[BIT_COMP_AUX_HOT]  = |st.vec.comp_aux_hot_vector;
		r[BIT_CAL_LSB +: NUM_CAL] = st.cal_fault;
		return r;
	endfunction

	// read mux; a write to the read-only summary or any unmapped address is an error
	function automatic asr_rsp_t asr_read(input asr_state_t st,
	                                      input logic [ADDR_W-1:0] addr,
	                                      input logic wr);
		asr_rsp_t r;
		r.err  = 1'b0;
		r.data = 32'h0000_0000;
		if (addr == ADDR_ALERT_SUMMARY) begin
			r.data[REG_W-1:0] = st.summary;
			r.err = wr;
		end else if (addr == ADDR_CELL_OV_EN) begin
			r.data[NUM_CELLS-1:0] = st.cell_ov_alert_enable;
		end else if (addr == ADDR_CELL_UV_EN) begin
			r.data[NUM_CELLS-1:0] = st.cell_uv_alert_enable;
		end else if (addr == ADDR_AUX_EN) begin
			r.data[NUM_AUX-1:0] = st.aux_cold_alert_enable;
			r.data[AUX_HOT_LSB +: NUM_AUX] = st.aux_hot_alert_enable;
		end else if (addr == ADDR_IRQ_STATUS) begin
			r.data[REG_W-1:0] = st.irq_status;
		end else if (addr == ADDR_IRQ_MASK) begin
			r.data[REG_W-1:0] = st.irq_mask;
		end else begin
			r.err = 1'b1;
		end
		return r;
	endfunction

	logic             setup_ph;
	logic             wr_acc;
	logic [REG_W-1:0] irq_clr;
	logic [REG_W-1:0] irq_set;
	asr_rsp_t         rsp;

	// next-state logic for the whole block
	always_comb begin
		next_s   = s;
		setup_ph = psel_i & ~penable_i;
		wr_acc   = psel_i & penable_i & pwrite_i;
		irq_clr  = SUMMARY_RST;
		irq_set  = SUMMARY_RST;
		rsp      = asr_read(s, paddr_i, pwrite_i);

		// each acquisition replaces the vectors, so a resolved cause drops out
		// and a still-present enabled one keeps the summary set
		if (acq_done_i) begin
			next_s.vec.cell_ov_vector = alert_cond_i.cell_ov_vector &
				s.cell_ov_alert_enable;
			next_s.vec.comp_cell_ov_vector = alert_cond_i.comp_cell_ov_vector &
				s.cell_ov_alert_enable;
			next_s.vec.cell_uv_vector = alert_cond_i.cell_uv_vector &
				s.cell_uv_alert_enable;
			next_s.vec.comp_cell_uv_vector = alert_cond_i.comp_cell_uv_vector &
				s.cell_uv_alert_enable;
			next_s.vec.aux_cold_vector = alert_cond_i.aux_cold_vector &
				s.aux_cold_alert_enable;
			next_s.vec.comp_aux_cold_vector = alert_cond_i.comp_aux_cold_vector &
				s.aux_cold_alert_enable;
			next_s.vec.aux_hot_vector = alert_cond_i.aux_hot_vector &
				s.aux_hot_alert_enable;
			next_s.vec.comp_aux_hot_vector = alert_cond_i.comp_aux_hot_vector &
				s.aux_hot_alert_enable;
		end

		// a fault only moves when a new result is judged; otherwise it holds
		for (int i = 0; i < NUM_CAL; i++) begin
			if (cal_evt_i.eval[i]) begin
				next_s.cal_fault[i] = ~cal_evt_i.in_bounds[i];
			end
		end

		// register writes take effect at the access edge; zero wait states
		if (wr_acc) begin
			if (paddr_i == ADDR_CELL_OV_EN) begin
				next_s.cell_ov_alert_enable = pwdata_i[NUM_CELLS-1:0];
			end else if (paddr_i == ADDR_CELL_UV_EN) begin
				next_s.cell_uv_alert_enable = pwdata_i[NUM_CELLS-1:0];
			end else if (paddr_i == ADDR_AUX_EN) begin
				next_s.aux_cold_alert_enable = pwdata_i[NUM_AUX-1:0];
				next_s.aux_hot_alert_enable  = pwdata_i[AUX_HOT_LSB +: NUM_AUX];
			end else if (paddr_i == ADDR_IRQ_STATUS) begin
				irq_clr = pwdata_i[REG_W-1:0];
			end else if (paddr_i == ADDR_IRQ_MASK) begin
				next_s.irq_mask = pwdata_i[REG_W-1:0];
			end
		end

		// summary is registered together with its sources, so it never lags them
		next_s.summary = asr_summary(next_s);

		// a summary bit going high is an event; set beats a same-cycle clear
		irq_set           = next_s.summary & ~s.summary;
		next_s.irq_status = (s.irq_status & ~irq_clr) | irq_set;
		next_s.irq        = |(next_s.irq_status & next_s.irq_mask);

		// read data is captured in the setup cycle so it comes from a flop
		if (setup_ph) begin
			next_s.prdata  = pwrite_i ? 32'h0000_0000 : rsp.data;
			next_s.pslverr = rsp.err;
		end
	end

	// single state register; everything resets to zero
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign prdata_o        = s.prdata;
	assign pslverr_o       = s.pslverr;
	assign pready_o        = 1'b1;        // every access completes in its first access cycle
	assign alert_summary_o = s.summary;
	assign irq_o           = s.irq;

endmodule

/* File: sim/asr_alert_summary_props.sv */
// port checker for the alert summary register block
// assumes one clock domain and is bound onto asr_alert_summary
`timescale 1ns/1ps

module asr_alert_summary_props
	import asr_pkg::*;
(
	input  wire logic              core_clk_i,     // core clock
	input  wire logic              rst_n_i,        // async reset, active low
	input  wire logic              psel_i,         // apb select
	input  wire logic              penable_i,      // apb access phase
	input  wire logic              pwrite_i,       // apb direction
	input  wire logic [ADDR_W-1:0] paddr_i,        // apb byte address
	input  wire logic              pslverr_o,      // apb error
	input  wire asr_alert_vec_t    alert_cond_i,   // live conditions
	input  wire logic              acq_done_i,     // acquisition pulse
	input  wire asr_cal_evt_t      cal_evt_i,      // calibration events
	input  wire logic [REG_W-1:0]  alert_summary_o // summary value
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);

	// a clean acquisition must clear the summaries it feeds, whatever the enables are
	property p_ov_clr;
		acq_done_i && alert_cond_i.cell_ov_vector == '0 && alert_cond_i.comp_cell_ov_vector == '0
		|=> alert_summary_o[15:14] == 2'b00;
	endproperty
	a_ov_clr: assert property (p_ov_clr) else $error("ov summary not cleared");
	property p_uv_clr;
		acq_done_i && alert_cond_i.cell_uv_vector == '0 && alert_cond_i.comp_cell_uv_vector == '0
		|=> alert_summary_o[13:12] == 2'b00;
	endproperty
	a_uv_clr: assert property (p_uv_clr) else $error("uv summary not cleared");
	property p_aux_clr;
		acq_done_i && alert_cond_i[4*NUM_AUX-1:0] == '0 |=> alert_summary_o[11:8] == 4'h0;
	endproperty
	a_aux_clr: assert property (p_aux_clr) else $error("aux summary not cleared");
	// between acquisitions the alert summaries may not move
	property p_hold;
		!acq_done_i |=> $stable(alert_summary_o[15:8]);
	endproperty
	a_hold: assert property (p_hold) else $error("summary moved without acquisition");
	property p_ov_cause;
		$rose(alert_summary_o[15]) |-> $past(acq_done_i && |alert_cond_i.cell_ov_vector);
	endproperty
	a_ov_cause: assert property (p_ov_cause) else $error("ov summary rose without cause");
	property p_uv_cause;
		$rose(alert_summary_o[13]) |-> $past(acq_done_i && |alert_cond_i.cell_uv_vector);
	endproperty
	a_uv_cause: assert property (p_uv_cause) else $error("uv summary rose without cause");
	// calibration faults follow the bounds result of their own run only
	property p_cal_adc;
		cal_evt_i.eval[4] |=> alert_summary_o[4] == !$past(cal_evt_i.in_bounds[4]);
	endproperty
	a_cal_adc: assert property (p_cal_adc) else $error("adc offset fault wrong");
	property p_cal_hold;
		!cal_evt_i.eval[4] |=> $stable(alert_summary_o[4]);
	endproperty
	a_cal_hold: assert property (p_cal_hold) else $error("adc offset fault moved");
	property p_cal_low;
		cal_evt_i.eval[0] |=> alert_summary_o[0] != $past(cal_evt_i.in_bounds[0]);
	endproperty
	a_cal_low: assert property (p_cal_low) else $error("ramp gain fault wrong");
	property p_ro;
		psel_i && !penable_i && pwrite_i && paddr_i == ADDR_ALERT_SUMMARY |=> pslverr_o;
	endproperty
	a_ro: assert property (p_ro) else $error("summary write not refused");
endmodule

bind asr_alert_summary asr_alert_summary_props asr_alert_summary_props_inst (
	.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
	.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pslverr_o(pslverr_o), .alert_cond_i(alert_cond_i),
	.acq_done_i(acq_done_i), .cal_evt_i(cal_evt_i), .alert_summary_o(alert_summary_o));

/* File: sim/test_asr_alert_summary.sv */
// self-checking bench for the alert summary register block
// assumes asr_pkg and the checker are compiled before it
`timescale 1ns/1ps

module test_asr_alert_summary
	import asr_pkg::*;
;
	logic                 core_clk, rst_n, psel, penable, pwrite, acq, pready, pslverr, irq, err;
	logic [ADDR_W-1:0]    paddr;
	logic [DATA_W-1:0]    pwdata, prdata, rd;
	logic [REG_W-1:0]     summary;
	logic [95:0]          r;
	asr_alert_vec_t       cond, c;
	asr_cal_evt_t         cal_evt;
	logic [NUM_CELLS-1:0] ov_en, uv_en;
	logic [NUM_AUX-1:0]   cold_en, hot_en;
	logic [NUM_CAL-1:0]   cal_exp;
	int                   num_errors, samples_checked;

	asr_alert_summary asr_alert_summary_inst (
		.core_clk_i(core_clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .alert_cond_i(cond), .acq_done_i(acq),
		.cal_evt_i(cal_evt), .alert_summary_o(summary), .irq_o(irq));

	// 200 MHz core clock
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	task automatic report_and_stop();
		$display("compares %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// one apb transfer; an idle cycle first so no signal is driven twice in one step
	task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		int n;
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) begin
			num_errors++;
			report_and_stop();
		end
	endtask

	// expected summary from the acquired conditions and the enables in force
	function automatic logic [REG_W-1:0] exp_sum(input asr_alert_vec_t v);
		return {|(v.cell_ov_vector & ov_en), |(v.comp_cell_ov_vector & ov_en),
			|(v.cell_uv_vector & uv_en), |(v.comp_cell_uv_vector & uv_en),
			|(v.aux_cold_vector & cold_en), |(v.comp_aux_cold_vector & cold_en),
			|(v.aux_hot_vector & hot_en), |(v.comp_aux_hot_vector & hot_en), 3'b000, cal_exp};
	endfunction

	// conditions change right after the pulse: only the pulse edge may sample them
	task automatic acquire(input asr_alert_vec_t v);
		@(posedge core_clk);
		cond <= v;
		acq <= 1'b1;
		@(posedge core_clk);
		acq <= 1'b0;
		cond <= ~v;
		@(negedge core_clk);
		chk("summary", 32'(summary), 32'(exp_sum(v)));
	endtask

	// calibration run on one index, other bounds bits random but not evaluated
	task automatic calib(input int i, input logic ok);
		logic [NUM_CAL-1:0] ib;
		ib = NUM_CAL'($urandom());
		ib[i] = ok;
		cal_exp[i] = !ok;
		@(posedge core_clk);
		cal_evt <= {NUM_CAL'(1 << i), ib};
		@(posedge core_clk);
		cal_evt <= '0;
		@(negedge core_clk);
		chk("cal faults", 32'(summary[4:0]), 32'(cal_exp));
	endtask

	// enables written over apb, mirrored for the expectation
	task automatic set_en();
		apb(1'b1, ADDR_CELL_OV_EN, 32'(ov_en));
		apb(1'b1, ADDR_CELL_UV_EN, 32'(uv_en));
		apb(1'b1, ADDR_AUX_EN, 32'({hot_en, 2'b00, cold_en}));
	endtask

	initial begin
		void'($urandom(87405));
		{rst_n, psel, penable, pwrite, acq, paddr, pwdata, cond, cal_evt} = '0;
		{ov_en, uv_en, cold_en, hot_en, cal_exp, num_errors, samples_checked} = '0;
		repeat (4) @(posedge core_clk);
		rst_n <= 1'b1;
		apb(1'b0, ADDR_ALERT_SUMMARY, 32'h0000_0000);
		chk("summary reset", rd, 32'h0000_0000);
		apb(1'b1, ADDR_ALERT_SUMMARY, 32'h0000_FFFF);
		chk("summary write err", 32'(err), 32'h0000_0001);
		apb(1'b0, 8'h60, 32'h0000_0000);
		chk("unmapped", {err, rd[30:0]}, 32'h8000_0000);
		{ov_en, uv_en, cold_en, hot_en} = '1;
		set_en();
		acquire('0);
		c = '0;
		c.cell_ov_vector[3] = 1'b1;
		acquire(c);
		chk("irq masked", 32'(irq), 32'h0000_0000);
		apb(1'b0, ADDR_IRQ_STATUS, 32'h0000_0000);
		chk("irq status", rd, 32'h0000_8000);
		apb(1'b1, ADDR_IRQ_MASK, 32'h0000_8000);
		@(negedge core_clk);
		chk("irq raised", 32'(irq), 32'h0000_0001);
		apb(1'b1, ADDR_IRQ_STATUS, 32'h0000_8000);
		acquire(c);
		chk("irq cleared", 32'(irq), 32'h0000_0000);
		// random enables and sparse conditions, every fourth one clean
		for (int k = 0; k < 40; k++) begin
			ov_en = NUM_CELLS'($urandom());
			uv_en = NUM_CELLS'($urandom());
			{cold_en, hot_en} = 12'($urandom());
			set_en();
			r = {$urandom(), $urandom(), $urandom()} & {$urandom(), $urandom(), $urandom()};
			r = r & {$urandom(), $urandom(), $urandom()};
			c = (k % 4 == 0) ? '0 : asr_alert_vec_t'(r[79:0]);
			acquire(c);
			apb(1'b0, ADDR_ALERT_SUMMARY, 32'h0000_0000);
			chk("summary read", rd, 32'(exp_sum(c)));
		end
		for (int i = 0; i < NUM_CAL; i++) calib(i, 1'b0);
		for (int i = NUM_CAL - 1; i >= 0; i--) calib(i, 1'b1);
		report_and_stop();
	end
endmodule
